//--- vsmm_consts.svh
// constants for the velocity status and min/max block
// assumes inclusion by bare name from the package and the top module
`ifndef VSMM_CONSTS_SVH
`define VSMM_CONSTS_SVH
`define VSMM_STATUS_BYTES      2
`define VSMM_RECORD_BYTES      8
`define VSMM_OFS_MIN           3'h0
`define VSMM_OFS_MAX           3'h4
`define VSMM_REC_INIT          32'h00000000
`define VSMM_REC_LIMIT         32'h00989680
`define VSMM_BIT_NOVALID       0
`define VSMM_BIT_STAT0         1
`define VSMM_BIT_DYN           5
`define VSMM_BIT_MOVING        6
`define VSMM_BIT_DIR           7
`define VSMM_BIT_CMP0          8
`define VSMM_NUM_STATIC        4
`define VSMM_NUM_CMP           5
`define VSMM_STATUS_INIT       16'h0000
`endif

//--- vsmm_pkg.sv
// types for the velocity status and min/max block
// assumes vsmm_consts.svh in the same folder
`default_nettype none
`include "vsmm_consts.svh"
package vsmm_pkg;
	typedef logic [31:0] vsmm_speed_t;
	typedef struct packed {
		logic        valid;
		logic        moving;
		logic        dir_neg;
		vsmm_speed_t speed;
	} vsmm_sample_s;
	typedef struct packed {
		logic [3:0]  en;
		logic [3:0]  below;
		logic [63:0] limits;
	} vsmm_static_cfg_s;
	typedef struct packed {
		logic        en;
		logic        below;
		logic [15:0] limit;
	} vsmm_dyn_cfg_s;
	typedef enum logic [1:0] {
		VSMM_IDLE = 2'b00,
		VSMM_FIRST = 2'b01,
		VSMM_TRACK = 2'b10
	} vsmm_rec_e;
endpackage
`default_nettype wire

//--- vsmm_limit_cmp.sv
// one velocity limit comparator with direction select
// assumes speed and limit in the same scaled unit, same clock
`timescale 1ns/10ps
`default_nettype none
module vsmm_limit_cmp
	import vsmm_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        en,
	input  wire logic        below,
	input  wire logic        valid,
	input  wire logic [15:0] limit,
	input  wire logic [31:0] speed,
	output logic             hit_q
);
	wire logic above_w = speed > {16'h0000, limit};
	wire logic under_w = speed < {16'h0000, limit};
	wire logic hit_d   = en & valid & (below ? under_w : above_w);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= hit_d;
		end
	end
endmodule
`default_nettype wire

//--- vsmm_top.sv
// velocity status word and min/max velocity record
// assumes samples, limit setup and record commands on sys_clk
// Summary of operation
// - status word is two bytes wide for the master.
// - bit 0 flags that no valid velocity was determined.
// - four static limit flags, one per configured limit.
// - one flag for the dynamic limit being violated.
// - limit flag is one only while beyond limit in chosen direction.
// - movement flag follows current motion detection.
// - direction bit means something only while bit 6 is set.
// - per limit, a flag shows whether comparison is active.
// - largest and smallest velocity are tracked and reported.
// - record start and stop come from the measurement control input.
// - reset command returns both records to their init value.
// - minimum record, unsigned 32 bits at offset 0, init zero.
// - maximum record, unsigned 32 bits at offset 4, init zero.
// - eight-byte record block is read as one consistent snapshot when the min word is read first.
// - comparison-active flag is zero inactive, one active.
// - crossing a static limit sets its status flag.
`timescale 1ns/10ps
`default_nettype none
`include "vsmm_consts.svh"
module vsmm_top
	import vsmm_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire vsmm_pkg::vsmm_sample_s     sample,
	input  wire logic              sample_stb,
	input  wire vsmm_pkg::vsmm_static_cfg_s static_cfg,
	input  wire vsmm_pkg::vsmm_dyn_cfg_s    dyn_cfg,
	input  wire logic              rec_start,
	input  wire logic              rec_stop,
	input  wire logic              rec_clear,
	input  wire logic              rd_stb,
	input  wire logic [2:0]        rd_ofs,
	output logic [15:0]            status_q,
	output logic [31:0]            rd_data_q,
	output logic                   rd_valid_q
);
	import vsmm_pkg::*;

	logic        rst_s1_q;
	logic        rst_n_q;
	vsmm_rec_e   st_q;
	vsmm_rec_e   st_d;
	vsmm_speed_t min_q;
	vsmm_speed_t max_q;
	vsmm_speed_t min_d;
	vsmm_speed_t max_d;
	vsmm_speed_t snap_max_q;
	logic [15:0] status_d;
	logic [4:0]  hit_w;

	// reset release is synchronised so every flop behind the two-stage synchroniser leaves reset on the same edge
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// static comparators
	// limitation: no hysteresis or position window, a flag follows the raw comparison
	genvar gi;
	generate
		for (gi = 0; gi < `VSMM_NUM_STATIC; gi = gi + 1) begin : g_stat
			vsmm_limit_cmp u_cmp (
				.sys_clk (sys_clk),
				.rst_n   (rst_n_q),
				.en      (static_cfg.en[gi]),
				.below   (static_cfg.below[gi]),
				.valid   (sample.valid),
				.limit   (static_cfg.limits[gi*16 +: 16]),
				.speed   (sample.speed),
				.hit_q   (hit_w[gi])
			);
		end
	endgenerate

	vsmm_limit_cmp u_dyn (
		.sys_clk (sys_clk),
		.rst_n   (rst_n_q),
		.en      (dyn_cfg.en),
		.below   (dyn_cfg.below),
		.valid   (sample.valid),
		.limit   (dyn_cfg.limit),
		.speed   (sample.speed),
		.hit_q   (hit_w[4])
	);

	// status word assembly; upper unused bits read zero
	// direction forced low while standing so a careless master sees a stable value
	wire logic       dir_w     = sample.moving & sample.dir_neg;
	wire logic [4:0] cmp_act_w = {dyn_cfg.en, static_cfg.en};
	always_comb begin
		status_d = `VSMM_STATUS_INIT;
		status_d[`VSMM_BIT_NOVALID] = ~sample.valid;
		status_d[`VSMM_BIT_STAT0 +: `VSMM_NUM_STATIC] = hit_w[3:0];
		status_d[`VSMM_BIT_DYN] = hit_w[4];
		status_d[`VSMM_BIT_MOVING] = sample.moving;
		status_d[`VSMM_BIT_DIR] = dir_w;
		status_d[`VSMM_BIT_CMP0 +: `VSMM_NUM_CMP] = cmp_act_w;
	end

	// record control
	// clear outranks stop and a sample arriving in the same cycle; a start with it still arms recording
	wire logic good_w = sample_stb & sample.valid;
	always_comb begin
		st_d = st_q;
		case (st_q)
			VSMM_IDLE:  begin
				if (rec_start) begin
					st_d = VSMM_FIRST;
				end
			end
			VSMM_FIRST: begin
				if (rec_stop) begin
					st_d = VSMM_IDLE;
				end else if (good_w) begin
					st_d = VSMM_TRACK;
				end
			end
			VSMM_TRACK: begin
				if (rec_stop) begin
					st_d = VSMM_IDLE;
				end
			end
			default: st_d = VSMM_IDLE;
		endcase
		if (rec_clear) begin
			st_d = (st_q == VSMM_IDLE && !rec_start) ? VSMM_IDLE : VSMM_FIRST;
		end
	end

	// speeds above the record range are pinned to its top so a read never leaves the range
	wire logic [31:0] spd_w = (sample.speed > `VSMM_REC_LIMIT) ? `VSMM_REC_LIMIT : sample.speed;
	wire logic load_w = (st_q == VSMM_FIRST) & good_w & ~rec_stop & ~rec_clear;
	wire logic trk_w  = (st_q == VSMM_TRACK) & good_w & ~rec_stop & ~rec_clear;

	always_comb begin
		min_d = min_q;
		max_d = max_q;
		if (rec_clear) begin
			min_d = `VSMM_REC_INIT;
			max_d = `VSMM_REC_INIT;
		end else if (load_w) begin
			min_d = spd_w;
			max_d = spd_w;
		end else if (trk_w) begin
			if (spd_w < min_q) begin
				min_d = spd_w;
			end
			if (spd_w > max_q) begin
				max_d = spd_w;
			end
		end
	end

	// state, records and status share one reset but sit in separate short blocks
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= VSMM_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			min_q <= `VSMM_REC_INIT;
			max_q <= `VSMM_REC_INIT;
		end else begin
			min_q <= min_d;
			max_q <= max_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= `VSMM_STATUS_INIT;
		end else begin
			status_q <= status_d;
		end
	end

	// offset decode shared by both record words
	function automatic logic vsmm_ofs_hit(input logic stb, input logic [2:0] ofs, input logic [2:0] want);
		vsmm_ofs_hit = stb & (ofs == want);
	endfunction

	// min word read freezes max so both words come from one update
	wire logic        rd_min_w = vsmm_ofs_hit(rd_stb, rd_ofs, `VSMM_OFS_MIN);
	wire logic        rd_max_w = vsmm_ofs_hit(rd_stb, rd_ofs, `VSMM_OFS_MAX);
	wire logic [31:0] rd_d     = rd_min_w ? min_q : (rd_max_w ? snap_max_q : 32'h00000000);

	// a max read alone returns the copy taken at the last min read, never the live record
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			snap_max_q <= `VSMM_REC_INIT;
		end else if (rd_min_w) begin
			snap_max_q <= max_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_data_q  <= 32'h00000000;
			rd_valid_q <= 1'b0;
		end else begin
			rd_data_q  <= rd_d;
			rd_valid_q <= rd_stb;
		end
	end
endmodule
`default_nettype wire

//--- vsmm_top_sva.sv
// checker for the velocity status word and record reads
// sees only vsmm_top ports, bound below
`timescale 1ns/10ps
`default_nettype none
module vsmm_top_chk
	import vsmm_pkg::*;
(
	input wire logic                     sys_clk,
	input wire logic                     resetn,
	input wire vsmm_pkg::vsmm_sample_s     sample,
	input wire vsmm_pkg::vsmm_static_cfg_s static_cfg,
	input wire vsmm_pkg::vsmm_dyn_cfg_s    dyn_cfg,
	input wire logic                     rec_clear,
	input wire logic                     rd_stb,
	input wire logic [2:0]               rd_ofs,
	input wire logic [15:0]              status_q,
	input wire logic [31:0]              rd_data_q,
	input wire logic                     rd_valid_q
);
	logic [1:0] up_q;
	// outputs stay cleared for two edges after release, so wait them out
	wire ok = up_q == 2'h3;
	wire [31:0] l0 = {16'h0000, static_cfg.limits[15:0]};
	wire [31:0] ld = {16'h0000, dyn_cfg.limit};
	wire h0 = sample.valid && static_cfg.en[0] && (static_cfg.below[0] ? sample.speed < l0 : sample.speed > l0);
	wire hd = sample.valid && dyn_cfg.en && (dyn_cfg.below ? sample.speed < ld : sample.speed > ld);
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn) up_q <= 2'h0;
		else if (!ok) up_q <= up_q + 2'h1;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_nv; ok |=> status_q[0] == !$past(sample.valid); endproperty
	a_nv: assert property (p_nv) else $error("no-valid flag wrong");
	property p_lim; ok |-> ##2 status_q[1] == $past(h0, 2); endproperty
	a_lim: assert property (p_lim) else $error("static flag wrong");
	property p_dyn; ok |-> ##2 status_q[5] == $past(hd, 2); endproperty
	a_dyn: assert property (p_dyn) else $error("dynamic flag wrong");
	property p_mov; ok |=> status_q[7:6] == $past({sample.moving & sample.dir_neg, sample.moving}); endproperty
	a_mov: assert property (p_mov) else $error("motion flags wrong");
	property p_cmp; ok |=> status_q[15:8] == $past({3'h0, dyn_cfg.en, static_cfg.en}); endproperty
	a_cmp: assert property (p_cmp) else $error("compare flags wrong");
	property p_rdv; ok |=> rd_valid_q == $past(rd_stb); endproperty
	a_rdv: assert property (p_rdv) else $error("read answer late");
	property p_clr; ok && rec_clear ##1 rd_stb && rd_ofs == 3'h0 |=> rd_data_q == 32'h0; endproperty
	a_clr: assert property (p_clr) else $error("clear not seen");
	property p_rng; rd_valid_q |-> rd_data_q <= 32'h00989680; endproperty
	a_rng: assert property (p_rng) else $error("record out of range");
endmodule
bind vsmm_top vsmm_top_chk vsmm_top_chk_inst (.sys_clk(sys_clk), .resetn(resetn), .sample(sample),
	.static_cfg(static_cfg), .dyn_cfg(dyn_cfg), .rec_clear(rec_clear), .rd_stb(rd_stb), .rd_ofs(rd_ofs),
	.status_q(status_q), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
`default_nettype wire

//--- vsmm_master.sv
// master model reading the eight-byte record block
// assumes a one-cycle read answer on sys_clk
`timescale 1ns/10ps
`default_nettype none
module vsmm_master (
	input  wire logic        sys_clk,
	input  wire logic        rd_valid_q,
	input  wire logic [31:0] rd_data_q,
	output var  logic        rd_stb,
	output var  logic [2:0]  rd_ofs
);
	initial rd_stb = 1'b0;
	initial rd_ofs = 3'h0;
	// a missing answer reads as all ones so it never matches a record
	task automatic rd2(input logic [2:0] a, b, output logic [31:0] x, y);
		rd_ofs = a;
		rd_stb = 1'b1;
		@(posedge sys_clk);
		#1 x = rd_valid_q === 1'b1 ? rd_data_q : 32'hFFFFFFFF;
		rd_ofs = b;
		@(posedge sys_clk);
		#1 y = rd_valid_q === 1'b1 ? rd_data_q : 32'hFFFFFFFF;
		rd_stb = 1'b0;
		// one idle edge so a following call never raises rd_stb in the step that lowered it
		@(posedge sys_clk);
		#1;
	endtask
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for vsmm_top
// assumes the design, master model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import vsmm_pkg::*;
	logic sys_clk = 1'b0, resetn = 1'b0, sample_stb = 1'b0, rd_stb, rd_valid_q;
	vsmm_sample_s sample = '0;
	vsmm_static_cfg_s static_cfg = '0;
	vsmm_dyn_cfg_s dyn_cfg = '0;
	logic [2:0] cmd = 3'h0, rd_ofs;
	logic [15:0] status_q;
	logic [31:0] rd_data_q, mn, mx;
	int fail_count = 0, n_compared = 0;
	always #5 sys_clk = ~sys_clk;
	vsmm_top vsmm_top_inst (.sys_clk(sys_clk), .resetn(resetn), .sample(sample), .sample_stb(sample_stb),
		.static_cfg(static_cfg), .dyn_cfg(dyn_cfg), .rec_start(cmd[0]), .rec_stop(cmd[1]), .rec_clear(cmd[2]),
		.rd_stb(rd_stb), .rd_ofs(rd_ofs), .status_q(status_q), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
	vsmm_master vsmm_master_inst (.sys_clk(sys_clk), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
		.rd_stb(rd_stb), .rd_ofs(rd_ofs));
	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED %0t mismatch %h %h", $time, g, e);
			fail_count++;
		end
	endtask
	task automatic pair(input logic [31:0] a, b);
		vsmm_master_inst.rd2(3'h0, 3'h4, mn, mx);
		chk(mn, a);
		chk(mx, b);
	endtask
	// idle cycle between strobes so sample_stb is never set twice at once
	task automatic smp(input logic [2:0] f, input logic [31:0] s);
		sample = {f, s};
		sample_stb = 1'b1;
		@(posedge sys_clk);
		#1 sample_stb = 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic pulse(input logic [2:0] c);
		cmd = c;
		@(posedge sys_clk);
		#1 cmd = 3'h0;
	endtask
	task automatic test_done;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always begin
		repeat (2000) @(posedge sys_clk);
		$display("CHECK FAILED %0t timeout", $time);
		fail_count++;
		test_done();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 pair(32'h0, 32'h0);
		pulse(3'h1);
		smp(3'h4, 32'h1F4);
		smp(3'h4, 32'h12C);
		smp(3'h4, 32'h384);
		smp(3'h0, 32'h32);
		smp(3'h4, 32'h01000000);
		pair(32'h12C, 32'h00989680);
		pulse(3'h2);
		smp(3'h4, 32'h1);
		pair(32'h12C, 32'h00989680);
		pulse(3'h4);
		pair(32'h0, 32'h0);
		pulse(3'h1);
		smp(3'h4, 32'h2BC);
		smp(3'h4, 32'h320);
		pair(32'h2BC, 32'h320);
		vsmm_master_inst.rd2(3'h2, 3'h6, mn, mx);
		chk(mn, 32'h0);
		chk(mx, 32'h0);
		static_cfg = {4'h1, 4'h0, 64'h3E8};
		dyn_cfg = {1'b1, 1'b1, 16'hBB8};
		smp(3'h7, 32'h7D0);
		chk({16'h0, status_q}, 32'h11E2);
		smp(3'h0, 32'h7D0);
		chk({16'h0, status_q}, 32'h1101);
		// a sample lands in the same edge as the min read; max must still be the old one
		fork
			vsmm_master_inst.rd2(3'h0, 3'h4, mn, mx);
			smp(3'h4, 32'hBB8);
		join
		chk(mn, 32'h2BC);
		chk(mx, 32'h7D0);
		pair(32'h2BC, 32'hBB8);
		// clear while recording re-arms, so the next good sample loads both
		pulse(3'h4);
		smp(3'h4, 32'h64);
		pair(32'h64, 32'h64);
		// mid-run reset returns both records to their init value
		resetn = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 pair(32'h0, 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
